// file: mbcds_top.sv
// multi bank clock divider select: source selection, bank dividers, coincidence marker and register slave
`timescale 1ns/1ps
module mbcds_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]          s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // reference and oscillator pins, asynchronous
   input  wire logic                       single_ended_ref_a,
   input  wire logic                       single_ended_ref_b,
   input  wire logic                       diff_ref_pos,
   input  wire logic                       diff_ref_neg,
   input  wire logic                       osc_clock_in,
   input  wire logic                       loop_return_in,
   // freeze serial port pins, asynchronous
   input  wire logic                       freeze_shift_clock,
   input  wire logic                       freeze_config_serial_in,
   // levels handed to the loop's phase detector
   output logic                            loop_ref_level,
   output logic                            loop_return_level,
   // clock outputs and their common enable
   output mbcds_pkg::mbcds_outputs_type    clock_outputs,
   output logic                            clock_outputs_oe
);

   localparam int NSYNC = 8;

   mbcds_pkg::mbcds_ctrl_type   ctrl;
   mbcds_pkg::mbcds_ctrl_type   ctrl_prev;
   mbcds_pkg::mbcds_status_type status;
   logic [NSYNC-1:0]            pin_meta;
   logic [NSYNC-1:0]            pin_sync;
   logic                        ref_level;
   logic                        ref_prev;
   logic                        osc_prev;
   logic                        osc_half;
   logic                        ref_tick;
   logic                        osc_tick;
   logic                        src_tick;
   logic                        div_clear;
   logic                        fclk_prev;
   logic [31:0]                 freeze_shift;
   logic [mbcds_pkg::RATIO_W-1:0] ratio_a;
   logic [mbcds_pkg::RATIO_W-1:0] ratio_b;
   logic [mbcds_pkg::RATIO_W-1:0] ratio_c;
   logic [mbcds_pkg::RATIO_W-1:0] ratio_fb;
   logic [mbcds_pkg::RATIO_W-1:0] count_a;
   logic [mbcds_pkg::RATIO_W-1:0] count_c;
   logic                        div_a;
   logic                        div_b;
   logic                        div_c;
   logic                        div_fb;
   logic [mbcds_pkg::SYNC_W-1:0] sync_count;
   logic [mbcds_pkg::SYNC_W-1:0] next_sync_count;
   logic [mbcds_pkg::SYNC_W-1:0] joint_period;
   logic [mbcds_pkg::SYNC_W-1:0] lead_period;
   logic                        marker;
   logic                        aw_held;
   logic                        w_held;
   logic [7:0]                  aw_addr_q;
   logic [31:0]                 w_data_q;
   logic [3:0]                  w_strb_q;
   mbcds_pkg::mbcds_reg_type    wr_reg;
   mbcds_pkg::mbcds_reg_type    rd_reg;

   initial begin
      if (ADDR_W < 4 || ADDR_W > 32) begin
         $error("mbcds_top: ADDR_W must lie between 4 and 32");
      end
   end

   // smallest common multiple of two bank ratios, the joint period in source ticks
   function automatic logic [mbcds_pkg::SYNC_W-1:0] joint_ratio(
      input logic [mbcds_pkg::RATIO_W-1:0] ra,
      input logic [mbcds_pkg::RATIO_W-1:0] rc
   );
      logic [7:0] mult;
      logic       found;
      joint_ratio = '0;
      found       = 1'b0;
      for (int k = 1; k <= 12; k++) begin
         mult = 8'(ra * k);
         if (!found && (mult % {3'h0, rc}) == 8'h00) begin
            joint_ratio = mult[mbcds_pkg::SYNC_W-1:0];
            found       = 1'b1;
         end
      end
   endfunction

   // merge the written bytes into an old register value
   function automatic logic [31:0] apply_strobe(
      input logic [31:0] old_value,
      input logic [31:0] new_value,
      input logic [3:0]  strb
   );
      apply_strobe = old_value;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            apply_strobe[8*b +: 8] = new_value[8*b +: 8];
         end
      end
   endfunction

   // two-stage synchronisers for every pin; only the second stage is read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {freeze_config_serial_in, freeze_shift_clock, loop_return_in, osc_clock_in,
                      diff_ref_neg, diff_ref_pos, single_ended_ref_b, single_ended_ref_a};
         pin_sync <= pin_meta;
      end
   end

   // reference path choice; the differential level is pos high and neg low
   always_comb begin
      if (ctrl.ref_sel) begin
         ref_level = pin_sync[2] & ~pin_sync[3];
      end else if (ctrl.clk_sel) begin
         ref_level = pin_sync[1];
      end else begin
         ref_level = pin_sync[0];
      end
   end

   // edge detectors and the oscillator pre-divide toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_prev <= 1'b0;
         osc_prev <= 1'b0;
         osc_half <= 1'b0;
      end else begin
         ref_prev <= ref_level;
         osc_prev <= pin_sync[4];
         if (pin_sync[4] && !osc_prev) begin
            osc_half <= ~osc_half;
         end
      end
   end

   // source tick: oscillator (optionally halved) or the bypassed reference
   assign ref_tick = ref_level & ~ref_prev;
   assign osc_tick = (pin_sync[4] & ~osc_prev) & (ctrl.prediv | osc_half);
   assign src_tick = ctrl.pll_sel ? osc_tick : ref_tick;

   // ratio decode per bank; a ratio change restarts every divider so phases stay aligned
   assign ratio_a  = mbcds_pkg::bank_a_ratio(ctrl.a_sel);
   assign ratio_b  = mbcds_pkg::bank_b_ratio(ctrl.b_sel);
   assign ratio_c  = mbcds_pkg::bank_c_ratio(ctrl.c_sel);
   assign ratio_fb = mbcds_pkg::fb_ratio(ctrl.fb_sel);
   assign div_clear = !ctrl.oe ||
                      ({ctrl.a_sel, ctrl.b_sel, ctrl.c_sel, ctrl.fb_sel} !=
                       {ctrl_prev.a_sel, ctrl_prev.b_sel, ctrl_prev.c_sel, ctrl_prev.fb_sel});

   // independent dividers, all cleared together
   mbcds_divider #(.RATIO_W(mbcds_pkg::RATIO_W)) u_div_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (div_clear),
      .tick    (src_tick),
      .ratio   (ratio_a),
      .count   (count_a),
      .clk_out (div_a)
   );
   mbcds_divider #(.RATIO_W(mbcds_pkg::RATIO_W)) u_div_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (div_clear),
      .tick    (src_tick),
      .ratio   (ratio_b),
      .count   (),
      .clk_out (div_b)
   );
   mbcds_divider #(.RATIO_W(mbcds_pkg::RATIO_W)) u_div_c (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (div_clear),
      .tick    (src_tick),
      .ratio   (ratio_c),
      .count   (count_c),
      .clk_out (div_c)
   );
   mbcds_divider #(.RATIO_W(mbcds_pkg::RATIO_W)) u_div_fb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (div_clear),
      .tick    (src_tick),
      .ratio   (ratio_fb),
      .count   (),
      .clk_out (div_fb)
   );

   // joint period of banks a and c, and the lead: one period of the faster bank
   assign joint_period = joint_ratio(ratio_a, ratio_c);
   assign lead_period  = (ratio_a < ratio_c) ? ratio_a : ratio_c;

   // coincidence counter runs in step with the dividers; zero is a joint rising edge
   always_comb begin
      if (sync_count >= joint_period - 1'b1) begin
         next_sync_count = '0;
      end else begin
         next_sync_count = sync_count + 1'b1;
      end
   end

   // marker low in the last lead period, high again at the joint edge itself
   always_ff @(posedge aclk) begin
      if (!aresetn || div_clear) begin
         sync_count <= '1;
         marker     <= 1'b1;
      end else if (src_tick) begin
         sync_count <= next_sync_count;
         marker     <= !((next_sync_count >= joint_period - lead_period)
                         && (next_sync_count != '0));
      end
   end

   // registered outputs; disabled outputs hold low behind a low enable
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl.oe) begin
         clock_outputs    <= '0;
         clock_outputs_oe <= 1'b0;
      end else begin
         clock_outputs.bank_a   <= {4{div_a}};
         clock_outputs.bank_b   <= {4{div_b}};
         clock_outputs.bank_c   <= {{2{div_c ^ ctrl.invert}}, {2{div_c}}};
         clock_outputs.feedback <= div_fb;
         clock_outputs.marker   <= marker;
         clock_outputs_oe       <= 1'b1;
      end
   end

   // levels toward the loop: chosen reference and the returned feedback
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_ref_level    <= 1'b0;
         loop_return_level <= 1'b0;
      end else begin
         loop_ref_level    <= ref_level;
         loop_return_level <= pin_sync[5];
      end
   end

   // freeze port: shift one bit in on each rising freeze clock; the frame format is left to software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fclk_prev    <= 1'b0;
         freeze_shift <= '0;
      end else begin
         fclk_prev <= pin_sync[6];
         if (pin_sync[6] && !fclk_prev) begin
            freeze_shift <= {freeze_shift[30:0], pin_sync[7]};
         end
      end
   end

   // status snapshot
   assign status.sync_count  = sync_count;
   assign status.outputs_on  = clock_outputs_oe;
   assign status.ref_level   = loop_ref_level;
   assign status.loop_return = loop_return_level;
   assign status.marker      = marker;

   // write channels: address and data taken in either order, held until the response
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_reg        = mbcds_pkg::decode_reg(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= 8'(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
      end
   end

   // control register; its reset value mirrors the pull-ups
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= mbcds_pkg::CTRL_RESET[mbcds_pkg::CTRL_W-1:0];
         ctrl_prev <= mbcds_pkg::CTRL_RESET[mbcds_pkg::CTRL_W-1:0];
      end else begin
         ctrl_prev <= ctrl;
         if (aw_held && w_held && wr_reg == mbcds_pkg::REG_CTRL) begin
            ctrl <= mbcds_pkg::CTRL_W'(apply_strobe({17'h00000, ctrl}, w_data_q, w_strb_q));
         end
      end
   end

   // write response, error for anything but the control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mbcds_pkg::RESP_OKAY;
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_reg == mbcds_pkg::REG_CTRL) ? mbcds_pkg::RESP_OKAY : mbcds_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one outstanding read, data registered with the handshake
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_reg        = mbcds_pkg::decode_reg(8'(s_axi_araddr));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= mbcds_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mbcds_pkg::RESP_OKAY;
         case (rd_reg)
            mbcds_pkg::REG_CTRL:   s_axi_rdata <= {17'h00000, ctrl};
            mbcds_pkg::REG_STATUS: s_axi_rdata <= {23'h000000, status};
            mbcds_pkg::REG_FREEZE: s_axi_rdata <= freeze_shift;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= mbcds_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// file: mbcds_pkg.sv
// shared constants, types and decode functions for the multi bank clock divider select block
package mbcds_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET = 8'h04;
   localparam logic [7:0]  FREEZE_OFFSET = 8'h08;

   // control register: every select reads high out of reset, as the pull-ups would
   localparam logic [31:0] CTRL_RESET    = 32'h00007fff;
   localparam int          CTRL_W        = 15;

   // widths of the divider and coincidence counters
   localparam int          RATIO_W       = 5;
   localparam int          SYNC_W        = 5;

   // axi response codes
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // control register layout, bit 0 is the output enable
   typedef struct packed {
      logic [2:0] fb_sel;
      logic [1:0] c_sel;
      logic [1:0] b_sel;
      logic [1:0] a_sel;
      logic       invert;
      logic       prediv;
      logic       clk_sel;
      logic       ref_sel;
      logic       pll_sel;
      logic       oe;
   } mbcds_ctrl_type;

   // status register layout, low bits
   typedef struct packed {
      logic [SYNC_W-1:0] sync_count;
      logic              outputs_on;
      logic              ref_level;
      logic              loop_return;
      logic              marker;
   } mbcds_status_type;

   // the fourteen driven outputs
   typedef struct packed {
      logic [3:0] bank_a;
      logic [3:0] bank_b;
      logic [3:0] bank_c;
      logic       feedback;
      logic       marker;
   } mbcds_outputs_type;

   // one-hot register selection
   typedef enum logic [3:0] {
      REG_CTRL   = 4'b0001,
      REG_STATUS = 4'b0010,
      REG_FREEZE = 4'b0100,
      REG_NONE   = 4'b1000
   } mbcds_reg_type;

   function automatic mbcds_reg_type decode_reg(input logic [7:0] addr);
      case (addr)
         CTRL_OFFSET:   decode_reg = REG_CTRL;
         STATUS_OFFSET: decode_reg = REG_STATUS;
         FREEZE_OFFSET: decode_reg = REG_FREEZE;
         default:       decode_reg = REG_NONE;
      endcase
   endfunction

   function automatic logic [RATIO_W-1:0] bank_a_ratio(input logic [1:0] sel);
      case (sel)
         2'h0:    bank_a_ratio = 5'h04;
         2'h1:    bank_a_ratio = 5'h06;
         2'h2:    bank_a_ratio = 5'h08;
         default: bank_a_ratio = 5'h0c;
      endcase
   endfunction

   function automatic logic [RATIO_W-1:0] bank_b_ratio(input logic [1:0] sel);
      case (sel)
         2'h0:    bank_b_ratio = 5'h04;
         2'h1:    bank_b_ratio = 5'h06;
         2'h2:    bank_b_ratio = 5'h08;
         default: bank_b_ratio = 5'h0a;
      endcase
   endfunction

   function automatic logic [RATIO_W-1:0] bank_c_ratio(input logic [1:0] sel);
      case (sel)
         2'h0:    bank_c_ratio = 5'h02;
         2'h1:    bank_c_ratio = 5'h04;
         2'h2:    bank_c_ratio = 5'h06;
         default: bank_c_ratio = 5'h08;
      endcase
   endfunction

   function automatic logic [RATIO_W-1:0] fb_ratio(input logic [2:0] sel);
      case (sel)
         3'h0:    fb_ratio = 5'h04;
         3'h1:    fb_ratio = 5'h06;
         3'h2:    fb_ratio = 5'h08;
         3'h3:    fb_ratio = 5'h0a;
         3'h4:    fb_ratio = 5'h08;
         3'h5:    fb_ratio = 5'h0c;
         3'h6:    fb_ratio = 5'h10;
         default: fb_ratio = 5'h14;
      endcase
   endfunction

endpackage

// file: mbcds_divider.sv
// even-ratio clock divider stepped by source ticks
`timescale 1ns/1ps
module mbcds_divider #(
   parameter int RATIO_W = 5
) (
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // control
   input  wire logic               clear,
   input  wire logic               tick,
   input  wire logic [RATIO_W-1:0] ratio,
   // state and divided clock
   output logic      [RATIO_W-1:0] count,
   output logic                    clk_out
);

   logic [RATIO_W-1:0] next_count;

   initial begin
      if (RATIO_W < 2) begin
         $error("mbcds_divider: RATIO_W must be at least 2");
      end
   end

   // wrap at ratio-1; the cleared value counts as the last phase, so the first tick is a rising edge
   always_comb begin
      if (count >= ratio - 1'b1) begin
         next_count = '0;
      end else begin
         next_count = count + 1'b1;
      end
   end

   // high for the first half of each output period
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         count   <= '1;
         clk_out <= 1'b0;
      end else if (tick) begin
         count   <= next_count;
         clk_out <= (next_count < (ratio >> 1));
      end
   end

endmodule

// file: mbcds_sva.sv
// port checker bound to the clock divider top
`timescale 1ns/1ps
module mbcds_sva (
   // clock and reset
   input wire logic                         aclk,
   input wire logic                         aresetn,
   // bus handshakes
   input wire logic                         s_axi_awready,
   input wire logic                         s_axi_wready,
   input wire logic                         s_axi_bvalid,
   input wire logic                         s_axi_bready,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic                         s_axi_rvalid,
   input wire logic                         s_axi_rready,
   // clock pins
   input wire mbcds_pkg::mbcds_outputs_type clock_outputs,
   input wire logic                         clock_outputs_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // joint rise of banks a and c, and a taken read request
   sequence joint_rise_s; $rose(clock_outputs.bank_a[0]) && $rose(clock_outputs.bank_c[0]); endsequence
   sequence ar_take_s; s_axi_arvalid && s_axi_arready; endsequence
   // two disabled cycles allow for the output register lagging the enable
   outputs_quiet_a: assert property (!clock_outputs_oe && !$past(clock_outputs_oe) |-> clock_outputs == '0)
      else $error("outputs active while disabled");
   marker_joint_a: assert property (joint_rise_s |-> clock_outputs.marker)
      else $error("marker low at joint rise");
   banks_whole_a: assert property (clock_outputs.bank_a inside {4'h0, 4'hf} && clock_outputs.bank_b inside {4'h0, 4'hf})
      else $error("bank outputs disagree");
   c_pairs_a: assert property (clock_outputs.bank_c[3] == clock_outputs.bank_c[2] && clock_outputs.bank_c[1] == clock_outputs.bank_c[0])
      else $error("bank c pair split");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped");
   write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_answer_a: assert property (ar_take_s |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
endmodule

bind mbcds_top mbcds_sva u_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .clock_outputs, .clock_outputs_oe);

// file: mbcds_ref_src.sv
// free-running reference and oscillator pin sources
`timescale 1ns/1ps
module mbcds_ref_src #(
   parameter int HA = 12,
   parameter int HB = 16,
   parameter int HD = 20,
   parameter int HO = 8
) (
   // references and oscillator
   output logic ref_a,
   output logic ref_b,
   output logic diff_pos,
   output logic diff_neg,
   output logic osc
);
   // 1 ns offset keeps every pin edge off the sampling clock edge
   initial begin
      {ref_a, ref_b, diff_pos, osc} = 4'h0;
      #1;
      fork
         forever #(HA) ref_a = ~ref_a;
         forever #(HB) ref_b = ~ref_b;
         forever #(HD) diff_pos = ~diff_pos;
         forever #(HO) osc = ~osc;
      join
   end
   assign diff_neg = ~diff_pos;
endmodule

// file: mbcds_top_bench.sv
// self-checking bench for the clock divider top
`timescale 1ns/1ps
module mbcds_top_bench;
   localparam int HA = 12, HB = 16, HD = 20, HO = 8;
   localparam int RA [4] = '{4, 6, 8, 12};
   localparam int RB [4] = '{4, 6, 8, 10};
   localparam int RC [4] = '{2, 4, 6, 8};
   localparam int RF [8] = '{4, 6, 8, 10, 8, 12, 16, 20};
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, freeze_shift_clock = 1'b0, freeze_config_serial_in = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h00008fa2;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, loop_ref_level, loop_return_level;
   logic single_ended_ref_a, single_ended_ref_b, diff_ref_pos, diff_ref_neg, osc_clock_in, clock_outputs_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   mbcds_pkg::mbcds_outputs_type clock_outputs;
   // loop levels ride above the clock outputs so one bit index reaches every watched output
   wire [15:0] watch = {loop_ref_level, loop_return_level, clock_outputs};
   logic [1:0] bq [$];
   logic [65:0] rq [$];
   int err_count = 0, tests_run = 0, cyc = 0;
   mbcds_ref_src #(.HA(HA), .HB(HB), .HD(HD), .HO(HO)) u_src (.ref_a(single_ended_ref_a),
      .ref_b(single_ended_ref_b), .diff_pos(diff_ref_pos), .diff_neg(diff_ref_neg), .osc(osc_clock_in));
   // feedback output is looped straight back as the return clock
   mbcds_top #(.ADDR_W(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .single_ended_ref_a, .single_ended_ref_b, .diff_ref_pos, .diff_ref_neg, .osc_clock_in,
      .loop_return_in(clock_outputs.feedback), .freeze_shift_clock, .freeze_config_serial_in,
      .loop_ref_level, .loop_return_level, .clock_outputs, .clock_outputs_oe);
   always #2 aclk = ~aclk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // response watcher takes the oldest note per answer; also cuts a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
      if (s_axi_rvalid && s_axi_rready) begin
         check("rdata", s_axi_rdata & rq[0][63:32], rq[0][31:0]);
         check("rresp", 32'(s_axi_rresp), 32'(rq.pop_front() >> 64));
      end
      if (cyc == 60000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
      rq.push_back({r, m, e & m});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   task automatic lvl(input int b, input logic v, inout int n);
      while (watch[b] !== v) begin
         @(posedge aclk);
         n++;
      end
   endtask
   // rise-to-rise spacing in clock cycles; counting starts at the first rise seen, so the part period before it is skipped
   task automatic per(input string what, input int b, input int exp);
      int n;
      n = 0;
      lvl(b, 1'b0, n);
      lvl(b, 1'b1, n);
      n = 0;
      lvl(b, 1'b0, n);
      lvl(b, 1'b1, n);
      check(what, 32'(n), 32'(exp));
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   initial begin
      logic [31:0] c;
      int src, lo, n;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      check("oe", 32'(clock_outputs_oe), 32'h1);
      rd(8'h00, 32'h00007fff, 32'hffffffff, 2'h0);
      rd(8'h0c, 32'h0, 32'hffffffff, 2'h2);
      wr(8'h04, 32'h0, 2'h2);
      per("bank a", 10, 12 * HO / 2);
      $display("test defaults done");
      // every feedback select code once, each bank select code twice; source bits walk all paths, predivide and invert random
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         c = {17'h0, i[2:0], i[1:0] + 2'h1, ~i[1:0], i[1:0], seed[1:0], i[2:0], 1'b1};
         wr(8'h00, c, 2'h0);
         rd(8'h00, c, 32'hffffffff, 2'h0);
         src = c[1] ? (c[4] ? HO / 2 : HO) : c[2] ? HD / 2 : c[3] ? HB / 2 : HA / 2;
         per("bank a", 10, RA[c[7:6]] * src);
         per("bank b", 6, RB[c[9:8]] * src);
         per("bank c", 2, RC[c[11:10]] * src);
         per("feedback", 1, RF[c[14:12]] * src);
         per("return level", 14, RF[c[14:12]] * src);
         per("ref level", 15, c[2] ? HD / 2 : c[3] ? HB / 2 : HA / 2);
         check("bank c third", 32'(clock_outputs.bank_c[2]), 32'(clock_outputs.bank_c[0] ^ c[5]));
         // marker low time: one faster-bank period, one tick less when both banks share a period
         lo = RA[c[7:6]] < RC[c[11:10]] ? RA[c[7:6]] : RC[c[11:10]];
         n = 0;
         lvl(0, 1'b1, n);
         lvl(0, 1'b0, n);
         n = 0;
         lvl(0, 1'b1, n);
         check("marker low", 32'(n), 32'((lo - int'(RA[c[7:6]] == RC[c[11:10]])) * src));
         $display("test config %0d done", i);
      end
      wr(8'h00, c & 32'hfffffffe, 2'h0);
      repeat (3) @(posedge aclk);
      check("oe", 32'(clock_outputs_oe), 32'h0);
      check("outputs", 32'(clock_outputs), 32'h0);
      rd(8'h04, 32'h0, 32'h00000008, 2'h0);
      wr(8'h00, c, 2'h0);
      per("bank a", 10, RA[c[7:6]] * src);
      $display("test enable done");
      seed = xs(seed);
      for (int k = 7; k >= 0; k--) begin
         freeze_config_serial_in <= seed[k];
         repeat (4) @(posedge aclk);
         freeze_shift_clock <= 1'b1;
         repeat (4) @(posedge aclk);
         freeze_shift_clock <= 1'b0;
      end
      repeat (8) @(posedge aclk);
      rd(8'h08, {24'h0, seed[7:0]}, 32'h000000ff, 2'h0);
      $display("test freeze done");
      repeat (4) @(posedge aclk);
      end_of_test();
   end
endmodule
